/* rotate_mask_map.svh */
// constants for the doubleword rotate-and-mask unit: offsets, fields, resets
// assumes: included by the package and by the unit; definitions only
`ifndef ROTATE_MASK_MAP_SVH
`define ROTATE_MASK_MAP_SVH

// ===================================================================
// register byte offsets on the avalon slave
`define OFF_CTRL 8'h00
`define OFF_INSN 8'h04
`define OFF_STATUS 8'h08
`define OFF_GPR_SEL 8'h0C
`define OFF_GPR_LO 8'h10
`define OFF_GPR_HI 8'h14
`define OFF_RES_LO 8'h18
`define OFF_RES_HI 8'h1C

// ===================================================================
// control and status bit positions, reset values
`define CTRL_MODE64 0
`define CTRL_SO 1
`define CTRL_RESET 2'h1
`define STS_DONE 0
`define STS_ILLEGAL 1
`define STS_BUSY 2

// ===================================================================
// instruction fields (word bit 31 is instruction bit 0)
`define F_OPC 31:26
`define F_RS 25:21
`define F_RA 20:16
`define F_RB 15:11
`define F_MBE 10:5
`define F_XO4 4:1
`define F_XO3 4:2
`define F_SH5 1
`define F_RC 0
`define OPC_ROTATE 6'h1E
`define XO_REG_CL 4'h8
`define XO_REG_CR 4'h9
`define XO_IMM_CL 3'h0

// ===================================================================
// datapath sizes
`define REG_W 64
`define GPR_COUNT 32
`define IDX_W 5
`define AMT_W 6

`endif

/* rotate_mask_pkg.sv */
// types shared by the rotate-and-mask unit
// assumes: rotate_mask_map.svh is on the include path
package rotate_mask_pkg;
`include "rotate_mask_map.svh"

    // ===============================================================
    // operation and sequencer encodings
    typedef enum logic [1:0] {
        OP_NONE, OP_REG_LEFT, OP_REG_RIGHT, OP_IMM_LEFT
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_SRC, ST_AMT, ST_EXEC
    } state_t;

    // ===============================================================
    // decoded instruction and condition field
    typedef struct packed {
        op_t op;
        logic [`IDX_W-1:0] src;
        logic [`IDX_W-1:0] tgt;
        logic [`IDX_W-1:0] amt;
        logic [`AMT_W-1:0] mbe;
        logic [`AMT_W-1:0] imm;
        logic rec;
    } decoded_t;

    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic so;
    } cr_field_t;
endpackage

/* gpr_file.sv */
// general-purpose register file, one write port and one registered read
// assumes: caller never needs the written word on the same edge it reads
module gpr_file #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ===============================================================
    // storage; no reset on the array so it maps onto ram
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data leave a register one edge after the address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

/* dword_rotate_mask_unit.sv */
// doubleword rotate-then-mask execution unit with its register file
// assumes: one clock; software drives it as an avalon-mm master
//
// Chosen here: the Avalon-MM register port and the address map.
`include "rotate_mask_map.svh"

// Notes on behaviour
// RULE1 - opcode 30, xo 8: register clear-left
// RULE2 - opcode 30, xo 9: register clear-right
// RULE3 - opcode 30, xo3 0: immediate clear-left
// RULE4 - register count uses low six bits only
// RULE5 - immediate form rotates by immediate count
// RULE6 - clear-left mask: ones begin..63
// RULE7 - clear-right mask: ones 0..end
// RULE8 - rotated value AND mask to target
// RULE9 - record flag updates condition field zero
// RULE10 - narrow mode raises illegal, no execute
// RULE11 - rotation circular, bit 0 most significant
// RULE12 - immediate amount: bit 30 high, 16-20 low
module dword_rotate_mask_unit
    import rotate_mask_pkg::*;
#(
    parameter int REG_W = `REG_W,
    parameter int REG_COUNT = `GPR_COUNT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest
);
    localparam int AMT_W = $clog2(REG_W);
    localparam int IDX_W = $clog2(REG_COUNT);

    // ===============================================================
    // helper functions

    // byte-lane merge for partial avalon writes
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // instruction decode; shared by the bus path and the checks
    function automatic decoded_t decode(input logic [31:0] w);
        decoded_t d;
        d.op = OP_NONE;
        d.src = w[`F_RS];
        d.tgt = w[`F_RA];
        d.amt = w[`F_RB];
        d.mbe = w[`F_MBE];
        // RULE12 immediate amount assembly
        d.imm = {w[`F_SH5], w[`F_RB]};
        d.rec = w[`F_RC];
        if (w[`F_OPC] == `OPC_ROTATE) begin
            // RULE1 register clear-left decode
            if (w[`F_XO4] == `XO_REG_CL) begin
                d.op = OP_REG_LEFT;
            // RULE2 register clear-right decode
            end else if (w[`F_XO4] == `XO_REG_CR) begin
                d.op = OP_REG_RIGHT;
            // RULE3 immediate clear-left decode
            end else if (w[`F_XO3] == `XO_IMM_CL) begin
                d.op = OP_IMM_LEFT;
            end
        end
        return d;
    endfunction

    // left rotate over the doubled word; msb-first numbering matches
    function automatic logic [REG_W-1:0] rotl(
        input logic [REG_W-1:0] x,
        input logic [AMT_W-1:0] n
    );
        logic [2*REG_W-1:0] t;
        t = {x, x} << n;
        return t[2*REG_W-1:REG_W];
    endfunction

    // ===============================================================
    // state
    state_t st_q, st_d;
    logic waitrequest_q;
    logic [31:0] readdata_q;
    logic [1:0] ctrl_q;
    logic [31:0] insn_q;
    decoded_t dec_q;
    logic [IDX_W-1:0] gpr_sel_q;
    logic [31:0] lo_stage_q;
    logic [REG_W-1:0] src_q;
    logic [REG_W-1:0] result_q;
    cr_field_t cr0_q;
    logic done_q;
    logic illegal_q;
    logic [REG_W-1:0] gpr_rdata;

    // ===============================================================
    // bus decode; requests are taken only while the sequencer idles
    wire logic acc = (read || write) && waitrequest_q && st_q == ST_IDLE;
    wire logic wr_acc = acc && write;
    wire logic rd_acc = acc && read;
    wire logic wr_ctrl = wr_acc && address == `OFF_CTRL;
    wire logic wr_insn = wr_acc && address == `OFF_INSN;
    wire logic wr_status = wr_acc && address == `OFF_STATUS;
    wire logic wr_sel = wr_acc && address == `OFF_GPR_SEL;
    wire logic wr_lo = wr_acc && address == `OFF_GPR_LO;
    wire logic wr_hi = wr_acc && address == `OFF_GPR_HI;

    // instruction word as merged by byte enables, then decoded
    wire logic [31:0] insn_new = be_merge(insn_q, writedata, byteenable);
    wire decoded_t dec_new = decode(insn_new);
    wire logic mode64 = ctrl_q[`CTRL_MODE64];
    wire logic legal_new = dec_new.op != OP_NONE && mode64;

    // RULE10 narrow mode or unknown form traps
    wire logic start = wr_insn && legal_new;
    wire logic trap = wr_insn && !legal_new;

    // ===============================================================
    // execution datapath, evaluated in ST_EXEC
    wire logic exec = st_q == ST_EXEC;
    wire logic [REG_W-1:0] amt_val = gpr_rdata;
    wire logic [REG_W-1:0] all_ones = '1;

    // RULE4 register count from low six bits
    wire logic [AMT_W-1:0] reg_amt = amt_val[AMT_W-1:0];
    // RULE5 immediate form uses the field count
    wire logic [AMT_W-1:0] rot_amt =
        (dec_q.op == OP_IMM_LEFT) ? dec_q.imm : reg_amt;

    // RULE11 circular rotate over the full word
    wire logic [REG_W-1:0] rotated = rotl(src_q, rot_amt);

    // RULE6 ones from begin position to bit 63
    wire logic [REG_W-1:0] mask_left = all_ones >> dec_q.mbe;
    // RULE7 ones from bit 0 to end position
    wire logic [REG_W-1:0] mask_right = ~((all_ones >> dec_q.mbe) >> 1);
    wire logic [REG_W-1:0] mask =
        (dec_q.op == OP_REG_RIGHT) ? mask_right : mask_left;

    // RULE8 masked result goes to the target
    wire logic [REG_W-1:0] wr_data = rotated & mask;

    // condition flags compare the result as a signed word against zero
    wire cr_field_t cr0_new = '{
        lt: wr_data[REG_W-1],
        gt: !wr_data[REG_W-1] && (|wr_data),
        eq: ~|wr_data,
        so: ctrl_q[`CTRL_SO]
    };

    // ===============================================================
    // register file port selection; bus and exec never overlap
    wire logic [IDX_W-1:0] rd_idx =
        (st_q == ST_SRC) ? dec_q.src :
        (st_q == ST_AMT) ? dec_q.amt : gpr_sel_q;
    wire logic [31:0] hi_new =
        be_merge(gpr_rdata[REG_W-1:32], writedata, byteenable);
    wire logic mem_we = exec || wr_hi;
    wire logic [IDX_W-1:0] mem_waddr = exec ? dec_q.tgt : gpr_sel_q;
    wire logic [REG_W-1:0] mem_wdata =
        exec ? wr_data : {hi_new, lo_stage_q};

    gpr_file #(
        .WIDTH(REG_W),
        .DEPTH(REG_COUNT),
        .AW(IDX_W)
    ) u_gpr (
        .clk(clk),
        .sys_rst(sys_rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(rd_idx),
        .rdata_q(gpr_rdata)
    );

    // ===============================================================
    // sequencer: fetch source, fetch amount, execute
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start) begin
                    st_d = ST_SRC;
                end
            end
            ST_SRC: st_d = ST_AMT;
            ST_AMT: st_d = ST_EXEC;
            ST_EXEC: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ===============================================================
    // avalon answer: waitrequest drops for exactly one edge per request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= !acc;
        end
    end

    // read selection; unmapped addresses read as zero
    wire logic [7:0] status_byte =
        {cr0_q, 1'b0, st_q != ST_IDLE, illegal_q, done_q};
    wire logic [31:0] rd_mux =
        (address == `OFF_CTRL) ? {30'h0, ctrl_q} :
        (address == `OFF_INSN) ? insn_q :
        (address == `OFF_STATUS) ? {24'h0, status_byte} :
        (address == `OFF_GPR_SEL) ? 32'(gpr_sel_q) :
        (address == `OFF_GPR_LO) ? gpr_rdata[31:0] :
        (address == `OFF_GPR_HI) ? gpr_rdata[REG_W-1:32] :
        (address == `OFF_RES_LO) ? result_q[31:0] :
        (address == `OFF_RES_HI) ? result_q[REG_W-1:32] : 32'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata_q <= 32'h0;
        end else if (rd_acc) begin
            readdata_q <= rd_mux;
        end
    end

    assign waitrequest = waitrequest_q;
    assign readdata = readdata_q;

    // ===============================================================
    // software-written registers
    wire logic [31:0] ctrl_new = be_merge({30'h0, ctrl_q}, writedata,
        byteenable);
    wire logic [31:0] sel_new = be_merge(32'(gpr_sel_q), writedata,
        byteenable);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `CTRL_RESET;
            gpr_sel_q <= '0;
            lo_stage_q <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= ctrl_new[1:0];
            if (wr_sel) gpr_sel_q <= sel_new[IDX_W-1:0];
            if (wr_lo) lo_stage_q <= be_merge(lo_stage_q, writedata,
                byteenable);
        end
    end

    // instruction capture; decode is held for the whole sequence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            insn_q <= 32'h0;
            dec_q <= '0;
        end else if (wr_insn) begin
            insn_q <= insn_new;
            dec_q <= dec_new;
        end
    end

    // source operand is caught two edges after its read address, at the edge that ends ST_AMT
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_q <= '0;
        end else if (st_q == ST_AMT) begin
            src_q <= gpr_rdata;
        end
    end

    // ===============================================================
    // results and condition field
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_q <= '0;
        end else if (exec) begin
            result_q <= wr_data;
        end
    end

    // RULE9 condition field only on record flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cr0_q <= '0;
        end else if (exec && dec_q.rec) begin
            cr0_q <= cr0_new;
        end
    end

    // sticky flags, write one to clear; a set in the same edge wins
    wire logic clr_done = wr_status && byteenable[0] &&
        writedata[`STS_DONE];
    wire logic clr_ill = wr_status && byteenable[0] &&
        writedata[`STS_ILLEGAL];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            done_q <= exec || (done_q && !clr_done);
            // RULE10 illegal instruction flag
            illegal_q <= trap || (illegal_q && !clr_ill);
        end
    end

    // ===============================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start;
        start;
    endsequence

    sequence s_fetch;
        st_q == ST_SRC ##1 st_q == ST_AMT ##1 exec;
    endsequence

    a_start_to_write: // RULE8
    assert property (s_start |=> s_fetch ##0
        (mem_we && mem_waddr == dec_q.tgt))
    else $error("execution did not write the target in three cycles");

    a_trap_no_exec: // RULE10
    assert property (trap |=> illegal_q && st_q == ST_IDLE)
    else $error("illegal instruction started or was not flagged");

    a_narrow_mode_trap: // RULE10
    assert property (wr_insn && !mode64 |=> !$past(start) && illegal_q)
    else $error("narrow mode executed an instruction");

    a_rotate_circular: // RULE11
    assert property (exec |-> rotated ==
        ((src_q << rot_amt) | (src_q >> (7'd64 - {1'b0, rot_amt}))))
    else $error("rotation is not circular");

    a_reg_amt_low: // RULE4
    assert property (exec && dec_q.op != OP_IMM_LEFT |->
        rot_amt == gpr_rdata[5:0])
    else $error("register count not the low six bits");

    a_imm_amount: // RULE12
    assert property (exec && dec_q.op == OP_IMM_LEFT |->
        rot_amt == {insn_q[1], insn_q[15:11]})
    else $error("immediate count assembled wrongly");

    a_mask_left_span: // RULE6
    assert property (exec && dec_q.op != OP_REG_RIGHT |->
        $countones(mask) == 64 - dec_q.mbe && mask[0])
    else $error("clear-left mask span wrong");

    a_mask_right_span: // RULE7
    assert property (exec && dec_q.op == OP_REG_RIGHT |->
        $countones(mask) == dec_q.mbe + 1 && mask[63])
    else $error("clear-right mask span wrong");

    a_record_hold: // RULE9
    assert property (exec && !dec_q.rec |=> $stable(cr0_q))
    else $error("condition field changed without record flag");

    a_record_eq: // RULE9
    assert property (exec && dec_q.rec |=>
        cr0_q.eq == (result_q == 0) && cr0_q.lt == result_q[63])
    else $error("condition field does not match result");

    a_bus_one_cycle: // bus answer: waitrequest low for one edge
    assert property (!waitrequest_q |=> waitrequest_q)
    else $error("waitrequest low for more than one cycle");
endmodule

/* bus_issue_model.sv */
// avalon-mm master standing in for the decode and issue logic
// assumes: clk is the unit's clock; only the bench calls the task
module bus_issue_model (
    input wire logic clk,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==============================================================
    // idle bus at time zero
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
    end

    // ==============================================================
    // one request, held until waitrequest is sampled low at an edge;
    // released lines are inverted so a stale value never looks valid
    task automatic xfer(input logic is_wr, input logic [7:0] addr,
            input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk);
        address <= addr;
        writedata <= wdata;
        read <= !is_wr;
        write <= is_wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~addr;
        writedata <= ~wdata;
    endtask
endmodule

/* dword_rotate_mask_unit_tb.sv */
// self-checking bench for the rotate-and-mask unit
// assumes: the unit's map header and package compiled first
`include "rotate_mask_map.svh"
module dword_rotate_mask_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==============================================================
    // clock, reset, bus wires, counters
    localparam logic [63:0] SRC_A = 64'h8123_4567_89AB_CDEF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [3:0] cond_exp = 4'h0; // {less, greater, zero, overflow}

    always #12.5 clk = ~clk;

    dword_rotate_mask_unit u_dword_rotate_mask_unit (.clk(clk),
        .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest));

    bus_issue_model u_bus_issue_model (.clk(clk), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest));

    // ==============================================================
    // compares and bus helpers
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check64(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        u_bus_issue_model.xfer(1'b1, a, d, unused);
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        u_bus_issue_model.xfer(1'b0, a, 32'h0000_0000, d);
    endtask

    task automatic gpr_set(input logic [4:0] idx, input logic [63:0] v);
        bus_wr(`OFF_GPR_SEL, {27'h0, idx});
        bus_wr(`OFF_GPR_LO, v[31:0]);
        bus_wr(`OFF_GPR_HI, v[63:32]);
    endtask

    task automatic gpr_get(input logic [4:0] idx, output logic [63:0] v);
        bus_wr(`OFF_GPR_SEL, {27'h0, idx});
        bus_rd(`OFF_GPR_LO, v[31:0]);
        bus_rd(`OFF_GPR_HI, v[63:32]);
    endtask

    // ==============================================================
    // one instruction: source in 3, count in 9, target 17; kind 1 is
    // register clear-left, 2 register clear-right, 3 immediate
    task automatic run_op(input logic [1:0] kind, input logic [63:0] src,
            input logic [63:0] amt_v, input logic [5:0] mbe,
            input logic rec, input logic ovf);
        logic [5:0] n;
        logic [63:0] rot;
        logic [63:0] mask;
        logic [63:0] exp;
        logic [63:0] got;
        logic [4:0] low;
        logic [31:0] rd;
        n = amt_v[5:0];
        // circular, vector msb is bit 0
        rot = (src << n) | (src >> (7'd64 - {1'b0, n}));
        if (kind == 2'd2) begin
            mask = {64{1'b1}} << (6'd63 - mbe);
        end else begin
            mask = {64{1'b1}} >> mbe;
        end
        exp = rot & mask;
        case (kind)
            2'd1: low = {`XO_REG_CL, rec};
            2'd2: low = {`XO_REG_CR, rec};
            default: low = {`XO_IMM_CL, n[5], rec};
        endcase
        bus_wr(`OFF_CTRL, {30'h0, ovf, 1'b1});
        gpr_set(5'd3, src);
        // immediate form must not look at the count register
        gpr_set(5'd9, (kind == 2'd3) ? ~amt_v : amt_v);
        bus_wr(`OFF_INSN, {`OPC_ROTATE, 5'd3, 5'd17,
            (kind == 2'd3) ? n[4:0] : 5'd9, mbe, low});
        gpr_get(5'd17, got);
        check64(got, exp);
        if (rec) begin
            cond_exp = {$signed(exp) < 0, $signed(exp) > 0, exp == 0, ovf};
        end
        bus_rd(`OFF_STATUS, rd);
        check32(rd, {24'h0, cond_exp, 4'h1});
        // the result copy must match what landed in the target
        bus_rd(`OFF_RES_LO, rd);
        check32(rd, exp[31:0]);
        bus_rd(`OFF_RES_HI, rd);
        check32(rd, exp[63:32]);
        bus_wr(`OFF_STATUS, 32'h0000_0003);
    endtask

    // ==============================================================
    // scenarios
    task automatic reset_values();
        logic [31:0] rd;
        bus_rd(`OFF_CTRL, rd);
        check32(rd, 32'h0000_0001);
        bus_rd(`OFF_STATUS, rd);
        check32(rd, 32'h0000_0000);
        // unmapped place: write ignored, reads zero
        bus_wr(8'h20, 32'hFFFF_FFFF);
        bus_rd(8'h20, rd);
        check32(rd, 32'h0000_0000);
    endtask

    task automatic reg_clear_left();
        run_op(2'd1, SRC_A, 64'hFFFF_FFFF_FFFF_FFC5, 6'd7, 1'b1, 1'b0);
        run_op(2'd1, SRC_A, 64'h0, 6'd0, 1'b1, 1'b0);
        run_op(2'd1, SRC_A, 64'h7F, 6'd63, 1'b0, 1'b0);
    endtask

    task automatic reg_clear_right();
        run_op(2'd2, SRC_A, 64'h8000_0000_0000_0041, 6'd62, 1'b1, 1'b1);
        run_op(2'd2, SRC_A, 64'h3F, 6'd0, 1'b1, 1'b0);
    endtask

    task automatic imm_clear_left();
        run_op(2'd3, SRC_A, 64'd37, 6'd3, 1'b1, 1'b0);
        run_op(2'd3, SRC_A, 64'd32, 6'd0, 1'b0, 1'b0);
        run_op(2'd3, 64'h1, 64'd0, 6'd63, 1'b1, 1'b0);
        // masked-out bit leaves zero, so the zero flag must rise
        run_op(2'd3, 64'h2, 64'd0, 6'd63, 1'b1, 1'b0);
    endtask

    task automatic illegal_forms();
        logic [63:0] got;
        logic [31:0] rd;
        gpr_set(5'd17, SRC_A);
        // narrow mode: a legal encoding must not execute
        bus_wr(`OFF_CTRL, 32'h0000_0000);
        bus_wr(`OFF_INSN, {`OPC_ROTATE, 5'd3, 5'd17, 5'd9, 6'd0,
            `XO_REG_CL, 1'b1});
        bus_rd(`OFF_STATUS, rd);
        check32(rd & 32'h0000_00F2, {24'h0, cond_exp, 4'h2});
        bus_wr(`OFF_STATUS, 32'h0000_0003);
        // wide mode, extended code outside the three forms
        bus_wr(`OFF_CTRL, 32'h0000_0001);
        bus_wr(`OFF_INSN, {`OPC_ROTATE, 5'd3, 5'd17, 5'd9, 6'd0,
            4'hA, 1'b1});
        bus_rd(`OFF_STATUS, rd);
        check32(rd & 32'h0000_00F2, {24'h0, cond_exp, 4'h2});
        gpr_get(5'd17, got);
        check64(got, SRC_A);
        bus_wr(`OFF_STATUS, 32'h0000_0003);
    endtask

    // ==============================================================
    // verdict, hang guard and main sequence
    task automatic stop_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a stuck waitrequest would otherwise hang the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        reset_values();
        reg_clear_left();
        reg_clear_right();
        imm_clear_left();
        illegal_forms();
        stop_test();
    end
endmodule
